// *** dsm_pkg.sv ***
// Package: register map, field positions, reset values and source codes of the modulator
package dsm_pkg;
  localparam int DSM_AW = 12;
  localparam logic [11:0] DSM_OFS_CTRL0 = 12'hF51;
  localparam logic [11:0] DSM_OFS_CARCTL = 12'hF52;
  localparam logic [11:0] DSM_OFS_SRC = 12'hF53;
  localparam logic [11:0] DSM_OFS_LOWER_CARRIER = 12'hF54;
  localparam logic [11:0] DSM_OFS_UPPER_CARRIER = 12'hF55;
  localparam logic [11:0] DSM_OFS_FIFO_DATA = 12'hF56;
  localparam logic [11:0] DSM_OFS_FIFO_STAT = 12'hF57;
  localparam int DSM_CTRL0_EN = 7;
  localparam int DSM_CTRL0_OUT = 5;
  localparam int DSM_CTRL0_OINV = 4;
  localparam int DSM_CTRL0_BIT = 0;
  localparam int DSM_CARCTL_HINV = 5;
  localparam int DSM_CARCTL_HSYNC = 4;
  localparam int DSM_CARCTL_LINV = 1;
  localparam int DSM_CARCTL_LSYNC = 0;
  localparam logic [7:0] DSM_RST_CTRL0 = 8'h00;
  localparam logic [7:0] DSM_RST_CARCTL = 8'h00;
  localparam logic [4:0] DSM_RST_SRC = 5'h00;
  localparam logic [3:0] DSM_RST_CAR = 4'h0;
  localparam logic [7:0] DSM_MASK_CTRL0 = 8'h91;
  localparam logic [7:0] DSM_MASK_CARCTL = 8'h33;
  localparam logic [4:0] DSM_SRC_PIN = 5'h00;
  localparam logic [4:0] DSM_SRC_SWBIT = 5'h01;
  localparam logic [4:0] DSM_SRC_FIFO = 5'h18;
  localparam int DSM_SRC_LAST = 23;
  localparam int DSM_CAR_LAST = 10;
  localparam int DSM_FIFO_DEPTH = 16;
  localparam int DSM_FIFO_WIDTH = 8;
  typedef enum logic [1:0] {
    DSM_USE_LOW = 2'b00,
    DSM_USE_HIGH = 2'b01,
    DSM_WAIT_HIGH = 2'b10,
    DSM_WAIT_LOW = 2'b11
  } dsm_car_state_t;
endpackage : dsm_pkg

// *** dsm_sync.sv ***
// Three-stage input synchroniser; a change counts once stages two and three agree
`timescale 1ns/1ns
module dsm_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q <= ((s2_r ~^ s3_r) & s3_r) | ((s2_r ^ s3_r) & q);
    end
  end
endmodule : dsm_sync

// *** dsm_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides, registered read data
`timescale 1ns/1ns
module dsm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic out_valid_r;
  logic push;
  logic pop;
  logic load;
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign push = in_valid & in_ready;
  // Output register acts as a prefetch stage so read data come from a flop
  assign load = (cnt_r != '0) & (~out_valid_r | out_ready);
  assign pop = out_valid_r & out_ready;
  assign out_valid = out_valid_r;
  assign level = cnt_r;
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      out_valid_r <= 1'b0;
      out_data <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + AW'(1);
      end
      if (load) begin
        rp_r <= rp_r + AW'(1);
        out_data <= mem_r[rp_r];
        out_valid_r <= 1'b1;
      end else if (pop) begin
        out_valid_r <= 1'b0;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(load);
    end
  end
endmodule : dsm_fifo

// *** dsm_modulator.sv ***
// Data signal modulator: carrier selection, sync, polarity, register port and data FIFO
//
// Summary of operation
// - Output is selected carrier ANDed with modulating data, before output inversion.
// - Data high uses the upper carrier; data low uses the lower carrier.
// - Enable starts modulation; clearing keeps selections; setting again resumes.
// - While disabled the output pin is held low.
// - Data source chosen by five-bit data source field.
// - Upper carrier chosen by four-bit upper carrier field.
// - Lower carrier chosen by four-bit lower carrier field.
// - With sync on, carrier switch waits until the current carrier goes low.
// - Separate sync bits govern leaving upper and lower carrier; clear means immediate.
// - Polarity bits invert the selected upper and lower carrier inputs.
// - Software data bit is a selectable data source.
// - Output invert bit inverts the final modulated output.
// - Keeps working in sleep while its sources run.
// - Any reset disables the block and restores every register default.
// - Power gate set holds block inactive; release restores defaults.
// - Read-only status bit shows the present modulated output.
`timescale 1ns/1ns
module dsm_modulator
  import dsm_pkg::*;
#(
  parameter int FIFO_WIDTH = DSM_FIFO_WIDTH,
  parameter int FIFO_DEPTH = DSM_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic modulator_power_gate,
  input wire logic [DSM_AW-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic data_pin,
  input wire logic upper_carrier_pin,
  input wire logic lower_carrier_pin,
  input wire logic [21:0] periph_data,
  input wire logic [9:0] periph_carrier,
  output logic modulated_output_pin
);
  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic clr;
  logic en_r;
  logic output_invert_r;
  logic software_data_bit_r;
  logic upper_carrier_invert_r;
  logic upper_carrier_sync_r;
  logic lower_carrier_invert_r;
  logic lower_carrier_sync_r;
  logic [4:0] data_source_field_r;
  logic [3:0] lower_carrier_field_r;
  logic [3:0] upper_carrier_field_r;
  logic out_r;
  logic [7:0] ctrl0_rd;
  logic [7:0] carctl_rd;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [FIFO_WIDTH-1:0] fifo_out_data;
  logic [$clog2(FIFO_DEPTH):0] fifo_level;
  logic [2:0] bit_cnt_r;
  logic fifo_push;

  // Power gate acts as a held reset so all state returns to defaults on release
  assign clr = rst | modulator_power_gate;

  // One write decode shared by every register and the FIFO port
  function automatic logic wr_hit(input logic wr, input logic [DSM_AW-1:0] a,
                                  input logic [DSM_AW-1:0] ofs);
    return wr && (a == ofs);
  endfunction : wr_hit

  logic wr_ctrl0;
  logic wr_carctl;
  logic wr_src;
  logic wr_lower_carrier;
  logic wr_upper_carrier;

  assign fifo_push = wr_hit(reg_wr, reg_addr, DSM_OFS_FIFO_DATA);
  assign wr_ctrl0 = wr_hit(reg_wr, reg_addr, DSM_OFS_CTRL0);
  assign wr_carctl = wr_hit(reg_wr, reg_addr, DSM_OFS_CARCTL);
  assign wr_src = wr_hit(reg_wr, reg_addr, DSM_OFS_SRC);
  assign wr_lower_carrier = wr_hit(reg_wr, reg_addr, DSM_OFS_LOWER_CARRIER);
  assign wr_upper_carrier = wr_hit(reg_wr, reg_addr, DSM_OFS_UPPER_CARRIER);

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      en_r <= DSM_RST_CTRL0[DSM_CTRL0_EN];
    end else if (wr_ctrl0) begin
      en_r <= reg_wdata[DSM_CTRL0_EN];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      output_invert_r <= DSM_RST_CTRL0[DSM_CTRL0_OINV];
      software_data_bit_r <= DSM_RST_CTRL0[DSM_CTRL0_BIT];
    end else if (wr_ctrl0) begin
      output_invert_r <= reg_wdata[DSM_CTRL0_OINV];
      software_data_bit_r <= reg_wdata[DSM_CTRL0_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      upper_carrier_invert_r <= DSM_RST_CARCTL[DSM_CARCTL_HINV];
      upper_carrier_sync_r <= DSM_RST_CARCTL[DSM_CARCTL_HSYNC];
    end else if (wr_carctl) begin
      upper_carrier_invert_r <= reg_wdata[DSM_CARCTL_HINV];
      upper_carrier_sync_r <= reg_wdata[DSM_CARCTL_HSYNC];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      lower_carrier_invert_r <= DSM_RST_CARCTL[DSM_CARCTL_LINV];
      lower_carrier_sync_r <= DSM_RST_CARCTL[DSM_CARCTL_LSYNC];
    end else if (wr_carctl) begin
      lower_carrier_invert_r <= reg_wdata[DSM_CARCTL_LINV];
      lower_carrier_sync_r <= reg_wdata[DSM_CARCTL_LSYNC];
    end
  end

  // Selections are only touched by writes, so disabling keeps them
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      data_source_field_r <= DSM_RST_SRC;
    end else if (wr_src) begin
      data_source_field_r <= reg_wdata[4:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      lower_carrier_field_r <= DSM_RST_CAR;
    end else if (wr_lower_carrier) begin
      lower_carrier_field_r <= reg_wdata[3:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      upper_carrier_field_r <= DSM_RST_CAR;
    end else if (wr_upper_carrier) begin
      upper_carrier_field_r <= reg_wdata[3:0];
    end
  end

  logic [7:0] src_rd;
  logic [7:0] lower_carrier_rd;
  logic [7:0] upper_carrier_rd;
  logic [7:0] fifo_stat_rd;
  logic [7:0] rd_mux;

  assign ctrl0_rd = {en_r, 1'b0, out_r, output_invert_r, 3'b000, software_data_bit_r};
  assign carctl_rd = {2'b00, upper_carrier_invert_r, upper_carrier_sync_r,
                      2'b00, lower_carrier_invert_r, lower_carrier_sync_r};
  assign src_rd = {3'b000, data_source_field_r};
  assign lower_carrier_rd = {4'h0, lower_carrier_field_r};
  assign upper_carrier_rd = {4'h0, upper_carrier_field_r};
  assign fifo_stat_rd = {fifo_in_ready, fifo_out_valid, 1'b0, 5'(fifo_level)};

  always_comb begin
    case (reg_addr)
      DSM_OFS_CTRL0: rd_mux = ctrl0_rd;
      DSM_OFS_CARCTL: rd_mux = carctl_rd;
      DSM_OFS_SRC: rd_mux = src_rd;
      DSM_OFS_LOWER_CARRIER: rd_mux = lower_carrier_rd;
      DSM_OFS_UPPER_CARRIER: rd_mux = upper_carrier_rd;
      DSM_OFS_FIFO_STAT: rd_mux = fifo_stat_rd;
      default: rd_mux = 8'h00;
    endcase
  end

  // Data stand one cycle only, so a stale byte is never taken for a fresh one
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial data stream from FIFO, LSB first, one bit per cycle
  dsm_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst(clr),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(reg_wdata[FIFO_WIDTH-1:0]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  // Stream only drains while enabled and selected; software must poll ready
  assign fifo_pop = fifo_out_valid & en_r & (data_source_field_r == DSM_SRC_FIFO) &
                    (bit_cnt_r == 3'(FIFO_WIDTH - 1));

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      bit_cnt_r <= 3'h0;
    end else if (fifo_out_valid && en_r && data_source_field_r == DSM_SRC_FIFO) begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation and selection
  logic [2:0] pins_s;
  logic [21:0] pdata_s;
  logic [9:0] pcar_s;

  dsm_sync #(.W(3)) u_sync_pin (
    .sys_clk(sys_clk),
    .rst(clr),
    .d({data_pin, upper_carrier_pin, lower_carrier_pin}),
    .q(pins_s)
  );

  dsm_sync #(.W(32)) u_sync_periph (
    .sys_clk(sys_clk),
    .rst(clr),
    .d({periph_carrier, periph_data}),
    .q({pcar_s, pdata_s})
  );

  function automatic logic pick_carrier(input logic [3:0] sel, input logic pin,
                                        input logic [9:0] per);
    logic r;
    r = 1'b0;
    if (sel == 4'h0) begin
      r = pin;
    end else if (int'(sel) <= DSM_CAR_LAST) begin
      r = per[sel - 4'h1];
    end
    return r;
  endfunction : pick_carrier

  logic modulating_data;
  logic upper_carrier;
  logic lower_carrier;
  logic fifo_bit;

  assign fifo_bit = fifo_out_valid & fifo_out_data[bit_cnt_r];

  always_comb begin
    modulating_data = 1'b0;
    if (data_source_field_r == DSM_SRC_PIN) begin
      modulating_data = pins_s[2];
    end else if (data_source_field_r == DSM_SRC_SWBIT) begin
      modulating_data = software_data_bit_r;
    end else if (data_source_field_r == DSM_SRC_FIFO) begin
      modulating_data = fifo_bit;
    end else if (int'(data_source_field_r) <= DSM_SRC_LAST) begin
      modulating_data = pdata_s[data_source_field_r - 5'h2];
    end
  end

  assign upper_carrier = pick_carrier(upper_carrier_field_r, pins_s[1], pcar_s) ^
                         upper_carrier_invert_r;
  assign lower_carrier = pick_carrier(lower_carrier_field_r, pins_s[0], pcar_s) ^
                         lower_carrier_invert_r;

  ////////////////////////////////////////////////////////////////////////////
  // Carrier hand-over with optional wait for the running carrier to fall
  dsm_car_state_t st_r;
  dsm_car_state_t st_nxt;
  logic use_high;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      DSM_USE_LOW: begin
        if (modulating_data) begin
          st_nxt = (lower_carrier_sync_r && lower_carrier) ? DSM_WAIT_LOW
                                                           : DSM_USE_HIGH;
        end
      end
      DSM_USE_HIGH: begin
        if (!modulating_data) begin
          st_nxt = (upper_carrier_sync_r && upper_carrier) ? DSM_WAIT_HIGH
                                                           : DSM_USE_LOW;
        end
      end
      DSM_WAIT_LOW: begin
        if (!modulating_data) begin
          st_nxt = DSM_USE_LOW;
        end else if (!lower_carrier || !lower_carrier_sync_r) begin
          st_nxt = DSM_USE_HIGH;
        end
      end
      DSM_WAIT_HIGH: begin
        if (modulating_data) begin
          st_nxt = DSM_USE_HIGH;
        end else if (!upper_carrier || !upper_carrier_sync_r) begin
          st_nxt = DSM_USE_LOW;
        end
      end
      default: st_nxt = DSM_USE_LOW;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      st_r <= DSM_USE_LOW;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Taken from the next state, so the cycle in which data flips already uses the new carrier unless a sync wait starts
  assign use_high = (st_nxt == DSM_USE_HIGH) || (st_nxt == DSM_WAIT_HIGH);

  ////////////////////////////////////////////////////////////////////////////
  // Output stage; registered, so pin lags inputs by one clock
  logic mixed;
  logic hold_nxt;
  logic keyed;
  // In sync wait the data has already flipped; keep carrier alone so the pulse completes
  assign hold_nxt = (st_nxt == DSM_WAIT_HIGH) || (st_nxt == DSM_WAIT_LOW);
  assign mixed = (use_high ? upper_carrier : lower_carrier) &
                 (modulating_data | hold_nxt);
  assign keyed = mixed ^ output_invert_r;

  // No clock gating, so operation in sleep only needs the clock and sources
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      out_r <= 1'b0;
    end else begin
      out_r <= en_r & keyed;
    end
  end

  assign modulated_output_pin = out_r;
endmodule : dsm_modulator

// *** dsm_src_model.sv ***
// Behavioural model of the peripherals that feed carriers and data
`timescale 1ns/1ns
module dsm_src_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sq_en,
  input wire logic [9:0] car_set,
  input wire logic [21:0] dat_set,
  output logic [9:0] periph_carrier,
  output logic [21:0] periph_data
);
  logic [3:0] div_r;
  // Square of 16 cycles, so that a sync wait meets a real falling edge
  always_ff @(posedge sys_clk) begin
    if (rst) div_r <= 4'h0;
    else div_r <= div_r + 4'h1;
  end
  assign periph_carrier = {car_set[9:1], sq_en ? div_r[3] : car_set[0]};
  assign periph_data = dat_set;
endmodule : dsm_src_model

// *** dsm_modulator_chk.sv ***
// Concurrent checks on the register port and the output pin
`timescale 1ns/1ns
module dsm_modulator_chk
  import dsm_pkg::*;
#(
  parameter int FIFO_WIDTH = DSM_FIFO_WIDTH,
  parameter int FIFO_DEPTH = DSM_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic modulator_power_gate,
  input wire logic [DSM_AW-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic modulated_output_pin
);
  logic [7:0] ctrl0_r;
  logic [7:0] carctl_r;
  logic [4:0] src_r;
  logic idle_bit;
  // Shadow of software writes; the power gate clears it like a reset
  always_ff @(posedge sys_clk) begin
    if (rst || modulator_power_gate) begin
      ctrl0_r <= DSM_RST_CTRL0;
      carctl_r <= DSM_RST_CARCTL;
      src_r <= DSM_RST_SRC;
    end else if (reg_wr) begin
      if (reg_addr == DSM_OFS_CTRL0) ctrl0_r <= reg_wdata & DSM_MASK_CTRL0;
      if (reg_addr == DSM_OFS_CARCTL) carctl_r <= reg_wdata & DSM_MASK_CARCTL;
      if (reg_addr == DSM_OFS_SRC) src_r <= reg_wdata[4:0];
    end
  end
  // Sync bits must be off, else a pending wait may still show the old carrier
  assign idle_bit = ctrl0_r[DSM_CTRL0_EN] && src_r == DSM_SRC_SWBIT
    && !ctrl0_r[DSM_CTRL0_BIT] && !carctl_r[DSM_CARCTL_HSYNC] && !carctl_r[DSM_CARCTL_LSYNC];
  ////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  unmapped_read_a:
    assert property (reg_rd && (reg_addr < DSM_OFS_CTRL0 || reg_addr > DSM_OFS_FIFO_STAT)
      |=> reg_rdata == 8'h00) else $error("unmapped read gave data");
  ctrl_readback_a:
    assert property (reg_rd && reg_addr == DSM_OFS_CTRL0
      |=> (reg_rdata & DSM_MASK_CTRL0) == $past(ctrl0_r)) else $error("control0 readback");
  carctl_readback_a:
    assert property (reg_rd && reg_addr == DSM_OFS_CARCTL
      |=> reg_rdata == $past(carctl_r)) else $error("carrier control readback");
  src_readback_a:
    assert property (reg_rd && reg_addr == DSM_OFS_SRC
      |=> reg_rdata == {3'h0, $past(src_r)}) else $error("source readback");
  car_field_a:
    assert property (reg_rd && (reg_addr == DSM_OFS_LOWER_CARRIER || reg_addr == DSM_OFS_UPPER_CARRIER)
      |=> reg_rdata[7:4] == 4'h0) else $error("carrier field upper bits set");
  out_status_a:
    assert property (reg_rd && reg_addr == DSM_OFS_CTRL0
      |=> reg_rdata[DSM_CTRL0_OUT] == $past(modulated_output_pin)) else $error("status bit");
  disabled_low_a:
    assert property (!ctrl0_r[DSM_CTRL0_EN] && !$past(ctrl0_r[DSM_CTRL0_EN])
      |-> !modulated_output_pin) else $error("output high while disabled");
  gate_quiet_a:
    assert property (modulator_power_gate
      |=> !modulated_output_pin && reg_rdata == 8'h00) else $error("gated block active");
  swbit_idle_a:
    assert property (idle_bit && $past(idle_bit) && $past(idle_bit, 2)
      |-> modulated_output_pin == ctrl0_r[DSM_CTRL0_OINV]) else $error("idle level");
  cover property (ctrl0_r[DSM_CTRL0_EN] && modulated_output_pin);
  cover property (modulator_power_gate);
  cover property (reg_rd && reg_addr == DSM_OFS_FIFO_STAT);
endmodule : dsm_modulator_chk

bind dsm_modulator dsm_modulator_chk #(.FIFO_WIDTH(FIFO_WIDTH), .FIFO_DEPTH(FIFO_DEPTH)) chk_u (
  .sys_clk(sys_clk), .rst(rst), .modulator_power_gate(modulator_power_gate),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .modulated_output_pin(modulated_output_pin));

// *** test_data_signal_modulator.sv ***
// Self-checking bench for the data signal modulator
`timescale 1ns/1ns
module test_data_signal_modulator import dsm_pkg::*; ();
  logic sys_clk = 1'b0, rst = 1'b1, pg = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic data_pin = 1'b0, uc_pin = 1'b0, lc_pin = 1'b0, sq_en = 1'b0, out;
  logic [9:0] car_set = 10'h000, pc;
  logic [21:0] dat_set = 22'h000000, pd;
  logic [23:0] dlvl;
  int error_cnt = 0, n_compared = 0;
  always #5 sys_clk = ~sys_clk;
  dsm_src_model src_u (.sys_clk(sys_clk), .rst(rst), .sq_en(sq_en), .car_set(car_set),
    .dat_set(dat_set), .periph_carrier(pc), .periph_data(pd));
  dsm_modulator dut_u (.sys_clk(sys_clk), .rst(rst), .modulator_power_gate(pg),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .data_pin(data_pin), .upper_carrier_pin(uc_pin),
    .lower_carrier_pin(lc_pin), .periph_data(pd), .periph_carrier(pc),
    .modulated_output_pin(out));
  ////////////////////////////////////////
  task conclude();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  task cmp_reg(input string n, input logic [7:0] e, input logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : cmp_reg
  // Long settle covers the input synchroniser plus the output register
  task cmp_out(input logic e);
    repeat (8) @(posedge sys_clk);
    #1;
    n_compared++;
    if (out !== e) begin
      error_cnt++;
      $display("unexpected output expected %b seen %b", e, out);
    end
  endtask : cmp_out
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // The status bit of control0 follows the pin, so it is masked here
  task rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    cmp_reg("register", e, reg_rdata & ((a == DSM_OFS_CTRL0) ? 8'hDF : 8'hFF));
  endtask : rd
  task set_lvl(input logic [10:0] l);
    uc_pin <= l[0];
    lc_pin <= l[0];
    car_set <= l[10:1];
  endtask : set_lvl
  task wait_out(input logic v);
    for (int i = 0; i < 40 && out !== v; i++) begin
      @(posedge sys_clk);
      #1;
    end
    if (out !== v) begin
      error_cnt++;
      $display("unexpected output wait expected %b seen %b", v, out);
      conclude();
    end
  endtask : wait_out
  ////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge sys_clk);
    error_cnt++;
    conclude();
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    for (int a = 12'hF50; a < 12'hF59; a++) rd(12'(a), (a == DSM_OFS_FIFO_STAT) ? 8'h80 : 8'h00);
    wr(DSM_OFS_CARCTL, 8'hFF);
    rd(DSM_OFS_CARCTL, 8'h33);
    wr(DSM_OFS_SRC, 8'hFF);
    rd(DSM_OFS_SRC, 8'h1F);
    wr(DSM_OFS_LOWER_CARRIER, 8'hFF);
    rd(DSM_OFS_LOWER_CARRIER, 8'h0F);
    wr(DSM_OFS_UPPER_CARRIER, 8'hFF);
    rd(DSM_OFS_UPPER_CARRIER, 8'h0F);
    wr(DSM_OFS_CTRL0, 8'hFF);
    rd(DSM_OFS_CTRL0, 8'h91);
    wr(DSM_OFS_CARCTL, 8'h00);
    wr(DSM_OFS_SRC, 8'h01);
    wr(DSM_OFS_CTRL0, 8'h81);
    for (int c = 0; c <= DSM_CAR_LAST; c++) begin
      set_lvl(11'h001 << c);
      wr(DSM_OFS_UPPER_CARRIER, 8'(c));
      cmp_out(1'b1);
      set_lvl(11'h000);
      cmp_out(1'b0);
    end
    set_lvl(11'h7FF);
    wr(DSM_OFS_UPPER_CARRIER, 8'h0B);
    cmp_out(1'b0);
    // Lower carrier only reaches the pin through a pending sync wait
    wr(DSM_OFS_CARCTL, 8'h01);
    for (int c = 0; c <= DSM_CAR_LAST; c++) begin
      set_lvl(11'h001 << c);
      wr(DSM_OFS_CTRL0, 8'h80);
      wr(DSM_OFS_LOWER_CARRIER, 8'(c));
      wr(DSM_OFS_CTRL0, 8'h81);
      cmp_out(1'b1);
      set_lvl(11'h000);
      cmp_out(1'b0);
    end
    wr(DSM_OFS_CARCTL, 8'h00);
    wr(DSM_OFS_UPPER_CARRIER, 8'h00);
    set_lvl(11'h001);
    wr(DSM_OFS_CTRL0, 8'h80);
    for (int s = 0; s <= DSM_SRC_LAST; s++) begin
      if (s == 1) continue;
      dlvl = 24'h000001 << s;
      data_pin <= dlvl[0];
      dat_set <= dlvl[23:2];
      wr(DSM_OFS_SRC, 8'(s));
      cmp_out(1'b1);
      data_pin <= 1'b0;
      dat_set <= 22'h000000;
      cmp_out(1'b0);
    end
    data_pin <= 1'b1;
    dat_set <= 22'h3FFFFF;
    wr(DSM_OFS_SRC, 8'h1F);
    cmp_out(1'b0);
    wr(DSM_OFS_SRC, 8'h01);
    wr(DSM_OFS_CTRL0, 8'h81);
    cmp_out(1'b1);
    wr(DSM_OFS_CARCTL, 8'h20);
    cmp_out(1'b0);
    wr(DSM_OFS_CTRL0, 8'h91);
    cmp_out(1'b1);
    wr(DSM_OFS_CTRL0, 8'h10);
    cmp_out(1'b0);
    rd(DSM_OFS_CARCTL, 8'h20);
    wr(DSM_OFS_CTRL0, 8'h91);
    cmp_out(1'b1);
    // Drop the data just after a carrier pulse starts, with and without sync
    wr(DSM_OFS_CARCTL, 8'h10);
    wr(DSM_OFS_UPPER_CARRIER, 8'h01);
    sq_en <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      wr(DSM_OFS_CTRL0, 8'h81);
      wait_out(1'b0);
      wait_out(1'b1);
      wr(DSM_OFS_CTRL0, 8'h80);
      @(posedge sys_clk);
      #1;
      cmp_reg("sync hold", (k == 0) ? 8'h01 : 8'h00, {7'h00, out});
      wr(DSM_OFS_CARCTL, 8'h00);
    end
    // Fill while the stream is stalled, then let it drain
    sq_en <= 1'b0;
    wr(DSM_OFS_CTRL0, 8'h00);
    wr(DSM_OFS_UPPER_CARRIER, 8'h00);
    for (int i = 0; i < 17; i++) wr(DSM_OFS_FIFO_DATA, 8'hFF);
    rd(DSM_OFS_FIFO_STAT, 8'h50);
    rd(DSM_OFS_FIFO_DATA, 8'h00);
    wr(DSM_OFS_SRC, 8'h18);
    wr(DSM_OFS_CTRL0, 8'h80);
    cmp_out(1'b1);
    repeat (150) @(posedge sys_clk);
    rd(DSM_OFS_FIFO_STAT, 8'h80);
    cmp_out(1'b0);
    for (int k = 0; k < 2; k++) begin
      wr(DSM_OFS_SRC, 8'h01);
      wr(DSM_OFS_CTRL0, 8'h81);
      @(posedge sys_clk);
      if (k == 0) pg <= 1'b1;
      else rst <= 1'b1;
      @(posedge sys_clk);
      pg <= 1'b0;
      rst <= 1'b0;
      cmp_out(1'b0);
      rd(DSM_OFS_SRC, 8'h00);
    end
    conclude();
  end
endmodule : test_data_signal_modulator
